//--- hdl/ecr_adv_select.sv
`default_nettype none

// ****************************************************************
// advertised eee ability selection
// ****************************************************************
module ecr_adv_select (
  input wire logic support,
  input wire logic adv_src_sel,
  input wire logic mmd_adv_eee,
  output logic adv_eee
);

  // no support masks all; otherwise own bit or mmd registers decide
  always_comb begin
    if (!support) begin
      adv_eee = 1'b0;
    end else if (adv_src_sel) begin
      adv_eee = support;
    end else begin
      adv_eee = mmd_adv_eee;
    end
  end

endmodule : ecr_adv_select

`default_nettype wire

//--- hdl/ecr_config_three.sv
`default_nettype none

// ****************************************************************
// energy efficient ethernet configuration register three
// ****************************************************************
module ecr_config_three (
  input wire logic clk,
  input wire logic rstn,
  input wire ecr_pkg::ecr_mgmt_req_s mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rd_valid,
  input wire logic mmd_adv_eee,
  input wire logic np_rx_valid,
  input wire logic lpi_quiet,
  output logic forced_lpi_on,
  output logic tx_lpi_force,
  output logic adv_eee,
  output logic np_accept,
  output logic rx_analog_off,
  output logic eee_supported,
  output ecr_pkg::ecr_tune_s tune
);

  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic hit;
  logic adv_sel;

  // ****************************************************************
  // register access
  // ****************************************************************

  assign hit = mgmt_req.addr == ecr_pkg::ECR_OFFSET;

  // masked write keeps reserved bits at zero; read answer one cycle after the strobe
  always_comb begin
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    rd_valid_next = 1'b0;
    if (hit && mgmt_req.wr) begin
      cfg_next = mgmt_req.wdata & ecr_pkg::ECR_WRITE_MASK;
    end
    if (hit && mgmt_req.rd) begin
      rdata_next = cfg_reg & ecr_pkg::ECR_WRITE_MASK;
      rd_valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_reg <= ecr_pkg::ECR_RESET;
      rdata_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign mgmt_rdata = rdata_reg;
  assign mgmt_rd_valid = rd_valid_reg;

  // ****************************************************************
  // control outputs
  // ****************************************************************

  ecr_adv_select u_adv (
    .support(cfg_reg[ecr_pkg::ECR_SUPPORT_BIT]),
    .adv_src_sel(cfg_reg[ecr_pkg::ECR_ADV_SRC_BIT]),
    .mmd_adv_eee(mmd_adv_eee),
    .adv_eee(adv_sel)
  );

  logic forced_next;
  logic tx_force_next;
  logic np_accept_next;
  logic rx_off_next;
  ecr_pkg::ecr_tune_s tune_next;

  // decode of the stored fields into internal controls
  always_comb begin
    forced_next = ecr_pkg::ecr_forced_lpi(
      cfg_reg[ecr_pkg::ECR_MODE_HI:ecr_pkg::ECR_MODE_LO]);
    // request only honoured once the mode is forced lpi
    tx_force_next = cfg_reg[ecr_pkg::ECR_TX_LPI_BIT] && ecr_pkg::ecr_forced_lpi(
      cfg_reg[ecr_pkg::ECR_MODE_HI:ecr_pkg::ECR_MODE_LO]);
    np_accept_next = np_rx_valid && !cfg_reg[ecr_pkg::ECR_NP_REJECT_BIT];
    rx_off_next = lpi_quiet && cfg_reg[ecr_pkg::ECR_RX_OFF_BIT];
    tune_next.reverse_loop_bypass_off = cfg_reg[ecr_pkg::ECR_TUNE_A_BIT];
    tune_next.fifo_bypass_off = cfg_reg[ecr_pkg::ECR_TUNE_B_BIT];
    tune_next.fast_wake_fallback_on = cfg_reg[ecr_pkg::ECR_FALLBACK_BIT];
    tune_next.idle_error_timer_value =
      cfg_reg[ecr_pkg::ECR_TIMER_HI:ecr_pkg::ECR_TIMER_LO];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      forced_lpi_on <= 1'b0;
      tx_lpi_force <= 1'b0;
      adv_eee <= 1'b0;
      np_accept <= 1'b0;
      rx_analog_off <= 1'b0;
      eee_supported <= 1'b0;
      tune <= '0;
    end else begin
      forced_lpi_on <= forced_next;
      tx_lpi_force <= tx_force_next;
      adv_eee <= adv_sel;
      np_accept <= np_accept_next;
      rx_analog_off <= rx_off_next;
      eee_supported <= cfg_reg[ecr_pkg::ECR_SUPPORT_BIT];
      tune <= tune_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_mode_decode: assert property (
    forced_lpi_on == $past(cfg_reg[14:13] == 2'h3))
    else $error("forced mode output does not follow code 3");
  chk_tx_force_order: assert property (
    tx_lpi_force |-> forced_lpi_on)
    else $error("transmit lpi forced without forced mode");
  chk_tx_force_set: assert property (
    (hit && mgmt_req.wr && mgmt_req.wdata[14:12] == 3'h7) |-> ##2 tx_lpi_force)
    else $error("transmit lpi force not raised two cycles after write");
  chk_adv_own_bit: assert property (
    (cfg_reg[3] && $stable(cfg_reg)) |=> adv_eee == $past(cfg_reg[0]))
    else $error("advertisement not taken from bit 0");
  chk_adv_mmd: assert property (
    (cfg_reg[1:0] != 2'h0 && !cfg_reg[3] && cfg_reg[0]) |=> adv_eee == $past(mmd_adv_eee))
    else $error("advertisement not taken from mmd registers");
  chk_np_reject: assert property (
    cfg_reg[2] |=> !np_accept)
    else $error("next page accepted while rejected");
  chk_rx_off: assert property (
    (lpi_quiet && cfg_reg[1]) |=> rx_analog_off)
    else $error("analog receive not shut down in quiet");
  chk_no_support: assert property (
    !cfg_reg[0] |=> (!adv_eee && !eee_supported))
    else $error("eee reported while support off");
  chk_reserved_zero: assert property (
    mgmt_rd_valid |-> (mgmt_rdata[15] == 1'b0 && mgmt_rdata[11] == 1'b0))
    else $error("reserved bit read as one");
  chk_read_back: assert property (
    (hit && mgmt_req.wr ##1 hit && mgmt_req.rd && !mgmt_req.wr) |=>
      mgmt_rdata == ($past(mgmt_req.wdata, 2) & 16'h77ff))
    else $error("read does not return written value");

  cov_forced: cover property (tx_lpi_force);
  cov_np_reject: cover property (np_rx_valid && cfg_reg[2]);
  cov_rx_off: cover property (rx_analog_off);
  cov_mmd_adv: cover property (!cfg_reg[3] && adv_eee);

endmodule : ecr_config_three

`default_nettype wire

//--- hdl/ecr_pkg.sv
`default_nettype none

// ****************************************************************
// energy efficient config three: shared constants and carriers
// ****************************************************************
package ecr_pkg;

  // register location and layout
  localparam logic [15:0] ECR_OFFSET = 16'h04d1;
  localparam logic [15:0] ECR_RESET = 16'h018b;
  localparam logic [15:0] ECR_WRITE_MASK = 16'h77ff; // bits 15 and 11 reserved

  localparam int ECR_MODE_HI = 14;
  localparam int ECR_MODE_LO = 13;
  localparam int ECR_TX_LPI_BIT = 12;
  localparam int ECR_TUNE_A_BIT = 10;
  localparam int ECR_TUNE_B_BIT = 9;
  localparam int ECR_FALLBACK_BIT = 8;
  localparam int ECR_TIMER_HI = 7;
  localparam int ECR_TIMER_LO = 4;
  localparam int ECR_ADV_SRC_BIT = 3;
  localparam int ECR_NP_REJECT_BIT = 2;
  localparam int ECR_RX_OFF_BIT = 1;
  localparam int ECR_SUPPORT_BIT = 0;

  // forced low-power mode codes
  localparam logic [1:0] ECR_MODE_OFF = 2'h0;
  localparam logic [1:0] ECR_MODE_FORCED_LPI = 2'h3;

  // management access request
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } ecr_mgmt_req_s;

  // undocumented tuning fields passed to internal logic
  typedef struct packed {
    logic reverse_loop_bypass_off;
    logic fifo_bypass_off;
    logic fast_wake_fallback_on;
    logic [3:0] idle_error_timer_value;
  } ecr_tune_s;

  // forced mode decode: only code 3 counts as forced lpi
  function automatic logic ecr_forced_lpi(input logic [1:0] code);
    return code == ECR_MODE_FORCED_LPI;
  endfunction : ecr_forced_lpi

endpackage : ecr_pkg

`default_nettype wire

//--- tb/ecr_config_three_tb.sv
`default_nettype none

`define CHECK_EQ(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module ecr_config_three_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  ecr_pkg::ecr_mgmt_req_s req = '0;
  logic mmd_adv_eee = 1'b0;
  logic np_rx_valid = 1'b0;
  logic lpi_quiet = 1'b0;
  logic [15:0] rdata;
  logic rd_valid, forced_lpi_on, tx_lpi_force, adv_eee, np_accept, rx_analog_off, eee_supported;
  ecr_pkg::ecr_tune_s tune;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  ecr_config_three u_dut (
    .clk(clk), .rstn(rstn), .mgmt_req(req), .mgmt_rdata(rdata), .mgmt_rd_valid(rd_valid),
    .mmd_adv_eee(mmd_adv_eee), .np_rx_valid(np_rx_valid), .lpi_quiet(lpi_quiet),
    .forced_lpi_on(forced_lpi_on), .tx_lpi_force(tx_lpi_force), .adv_eee(adv_eee),
    .np_accept(np_accept), .rx_analog_off(rx_analog_off), .eee_supported(eee_supported),
    .tune(tune)
  );

  // 250 MHz clock
  always #2 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  // one write strobe, then wait for the control outputs to follow
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr_reg

  // one read strobe, answer checked in the cycle it stands
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp, input logic vld);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    `CHECK_EQ(rd_valid, vld)
    if (vld) `CHECK_EQ(rdata, exp)
  endtask : rd_reg

  // write strobe, then a read strobe in the very next cycle
  task automatic wr_rd_reg(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    `CHECK_EQ(rd_valid, 1'b1)
    `CHECK_EQ(rdata, exp)
  endtask : wr_rd_reg

  task automatic final_report();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    logic [2:0] v;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHECK_EQ(adv_eee, 1'b1)
    `CHECK_EQ(eee_supported, 1'b1)
    `CHECK_EQ(tune, 7'h18)
    rd_reg(ecr_pkg::ECR_OFFSET, ecr_pkg::ECR_RESET, 1'b1);
    // mode code 3 taken as forced lpi; mode forced before the request bit
    wr_reg(ecr_pkg::ECR_OFFSET, 16'h6000);
    `CHECK_EQ(forced_lpi_on, 1'b1)
    wr_reg(ecr_pkg::ECR_OFFSET, 16'hffff);
    `CHECK_EQ(tune, 7'h7f)
    rd_reg(ecr_pkg::ECR_OFFSET, 16'h77ff, 1'b1);
    wr_reg(16'h04d2, 16'h0000);
    rd_reg(16'h04d2, 16'h0000, 1'b0);
    rd_reg(ecr_pkg::ECR_OFFSET, 16'h77ff, 1'b1);
    wr_rd_reg(ecr_pkg::ECR_OFFSET, 16'hfa5a, 16'h725a);
    `CHECK_EQ(tune, 7'h25)
    // every mode code, with and without the transmit request bit
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      wr_reg(ecr_pkg::ECR_OFFSET, {1'b0, v[2:1], v[0], 12'h000});
      `CHECK_EQ(forced_lpi_on, (v[2:1] == 2'h3))
      `CHECK_EQ(tx_lpi_force, (v[2:1] == 2'h3) & v[0])
    end
    // advertisement source against support bit and mmd input
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      @(posedge clk);
      mmd_adv_eee <= v[0];
      wr_reg(ecr_pkg::ECR_OFFSET, {12'h000, v[2], 2'b00, v[1]});
      `CHECK_EQ(adv_eee, v[1] & (v[2] | v[0]))
      `CHECK_EQ(eee_supported, v[1])
    end
    // next page reject and receive shutdown against their inputs
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      @(posedge clk);
      np_rx_valid <= v[0];
      lpi_quiet <= ~v[0];
      wr_reg(ecr_pkg::ECR_OFFSET, {13'h0000, v[2], v[1], 1'b0});
      `CHECK_EQ(np_accept, v[0] & ~v[2])
      `CHECK_EQ(rx_analog_off, ~v[0] & v[1])
    end
    final_report();
  end
endmodule : ecr_config_three_tb

`default_nettype wire
